// File: shared/utx_defines.vh
// constants for the serial transmitter with frame formatter
`ifndef UTX_DEFINES_VH
`define UTX_DEFINES_VH

// register byte offsets
`define UTX_OFS_STATUS   8'h00
`define UTX_OFS_DATA     8'h04
`define UTX_OFS_BAUD     8'h08
`define UTX_OFS_CTRL1    8'h0C
`define UTX_OFS_CTRL2    8'h10
`define UTX_OFS_CTRL3    8'h14

// status_register fields
`define UTX_ST_TBE       0
`define UTX_ST_TC        1
`define UTX_ST_BUSY      2

// control_register_one fields
`define UTX_C1_UE        0
`define UTX_C1_TE        1
`define UTX_C1_LEN       2
`define UTX_C1_PEN       3
`define UTX_C1_PSEL      4
`define UTX_C1_BRK       5
`define UTX_C1_TBEIE     6
`define UTX_C1_TCIE      7

// control_register_two fields
`define UTX_C2_STOP_LO   0
`define UTX_C2_SCE       2
`define UTX_C2_LIN       3

// control_register_three fields
`define UTX_C3_HD        0
`define UTX_C3_IR        1
`define UTX_C3_SC        2

// stop_bits_select codes
`define UTX_STOP_ONE     2'h0
`define UTX_STOP_HALF    2'h1
`define UTX_STOP_TWO     2'h2
`define UTX_STOP_ONEHALF 2'h3

// timing in oversample ticks
`define UTX_OVS          16
`define UTX_TICKS_HALF   6'h08
`define UTX_TICKS_ONE    6'h10
`define UTX_TICKS_ONEH   6'h18
`define UTX_TICKS_TWO    6'h20

// reset values
`define UTX_RST_BAUD     16'h0010
`define UTX_RST_CTRL     8'h00

// bus responses
`define UTX_RESP_OKAY    2'h0
`define UTX_RESP_SLVERR  2'h2

`endif

// File: core/utx_baud.v
// oversampling tick generator with a 12.4 fixed point divisor
`timescale 1ns/1ps
`include "utx_defines.vh"
module utx_baud #(
  parameter DIV_W = 16
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             run,
  input  wire [DIV_W-1:0] divisor,
  output reg              tick
);

  reg  [DIV_W:0] acc_r;
  wire [DIV_W:0] div_eff;
  wire [DIV_W:0] acc_add;

  // oversample step sized to the accumulator so no sum widens past it
  localparam [DIV_W:0] OVS = `UTX_OVS;

  // a divisor below one whole step would tick every cycle, so clamp it
  assign div_eff = ({1'b0, divisor} < OVS) ? OVS : {1'b0, divisor};
  assign acc_add = acc_r + OVS;

  // sixteen ticks per bit, so one bit lasts divisor clock cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= {(DIV_W+1){1'b0}};
      tick  <= 1'b0;
    end else if (!run) begin
      acc_r <= {(DIV_W+1){1'b0}};
      tick  <= 1'b0;
    end else if (acc_add >= div_eff) begin
      acc_r <= acc_add - div_eff;
      tick  <= 1'b1;
    end else begin
      acc_r <= acc_add;
      tick  <= 1'b0;
    end
  end

endmodule // utx_baud

// File: core/utx_top.v
// transmit half of a serial transceiver with an axi4-lite register slave
`timescale 1ns/1ps
`include "utx_defines.vh"

// Notes on behaviour
// - half-duplex enable selects single-wire mode; other mode enables must stay clear
// - in half-duplex the receive pin is cut and transmit line is open-drain, looped back
// - length and parity pick 8, 7+parity, 9 or 8+parity bits
// - stop field picks 1, 0.5, 2 or 1.5 stop bits; a break frame takes 2 for code 2 and 1 otherwise
// - parity select zero gives even parity, one gives odd
// - even parity makes total ones in data plus parity even
// - odd parity makes total ones in data plus parity odd
// - low start bit, data least significant first, then high stop bits
// - data write clears buffer-empty; word waits in buffer before shift register
// - word written during a frame moves to shifter when that frame ends
// - word written while idle loads at once, starts, and sets buffer-empty again
// - buffer-empty with its enable set raises the interrupt request
// - frame end with buffer empty sets completion flag; enable gates interrupt
// - break bit sends zeros for a frame, stop bits, then clears itself
// - break bit cleared before start sends nothing; re-arm after stop bit
// - enabling the transmitter first sends one idle frame of ones
// - enabled transmitter pulses the clock pin during data bits
// - enabled and not sending, transmit line stays high
// - 16-bit 12.4 divisor, sixteen ticks per bit
module utx_top #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire              tx_out,
  output wire              tx_oe,
  input  wire              rx_in,
  output wire              rx_to_receiver,
  output reg               serial_clock_out_pin,
  output wire              irq
);

  localparam S_IDLE = 2'd0;
  localparam S_BITS = 2'd1;
  localparam S_STOP = 2'd2;
  localparam K_DATA = 2'd0;
  localparam K_BRK  = 2'd1;
  localparam K_IDLE = 2'd2;

  // control and status state
  reg  [7:0]        ctrl1_r;
  reg  [3:0]        ctrl2_r;
  reg  [2:0]        ctrl3_r;
  reg  [15:0]       baud_divisor_r;
  reg  [8:0]        buf_r;
  reg               tbe_r;
  reg               tc_r;
  // bus state
  reg               aw_got_r;
  reg               w_got_r;
  reg  [ADDR_W-1:0] waddr_r;
  reg  [31:0]       wdata_r;
  reg  [3:0]        wstrb_r;
  // shifter state
  reg  [1:0]        state_r;
  reg  [1:0]        kind_r;
  reg  [9:0]        shreg_r;
  reg  [3:0]        tick_cnt_r;
  reg  [3:0]        bit_cnt_r;
  reg  [5:0]        stop_cnt_r;
  reg  [5:0]        stop_len_r;
  reg               tx_line_r;
  reg               en_d_r;
  reg               idle_pend_r;
  reg               done_r;

  wire        tick;
  wire        en;
  wire        do_write;
  wire [31:0] wval;
  wire        wr_data;
  wire        start_idle;
  wire        start_brk;
  wire        start_data;
  wire [3:0]  nbits;
  wire [31:0] old_word;
  reg  [31:0] rd_word;
  reg         rd_hit;
  reg  [5:0]  stop_sel_len;

  // merge written bytes over an old word
  function [31:0] utx_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      utx_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) utx_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // build start bit plus data and parity, lsb goes out first
  function [9:0] utx_frame;
    input [8:0] d;
    input       len;
    input       pen;
    input       odd;
    reg   [8:0] p;
    begin
      p = len ? d : {1'b0, d[7:0]};
      if (pen && len) begin
        p = {(^d[7:0]) ^ odd, d[7:0]};
      end else if (pen) begin
        p = {1'b0, (^d[6:0]) ^ odd, d[6:0]};
      end
      utx_frame = {p, 1'b0};
    end
  endfunction

  // the transmitter runs only with both the block and the transmitter enabled
  assign en = ctrl1_r[`UTX_C1_UE] & ctrl1_r[`UTX_C1_TE];

  utx_baud #(
    .DIV_W (16)
  ) u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (en),
    .divisor (baud_divisor_r),
    .tick    (tick)
  );

  // write channel: address and data are taken in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign do_write      = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_data       = do_write && (waddr_r == `UTX_OFS_DATA) && wstrb_r[0];

  // current value of the write-addressed register, used only by write merges
  assign old_word = (waddr_r == `UTX_OFS_BAUD)  ? {16'h0000, baud_divisor_r} :
                    (waddr_r == `UTX_OFS_CTRL1) ? {24'h000000, ctrl1_r} :
                    (waddr_r == `UTX_OFS_CTRL2) ? {28'h0000000, ctrl2_r} :
                    (waddr_r == `UTX_OFS_CTRL3) ? {29'h00000000, ctrl3_r} :
                    32'h00000000;
  assign wval = utx_merge(old_word, wdata_r, wstrb_r);

  // frame starts only between frames, idle first, then break; a break never reruns as it ends
  assign start_idle = en && (state_r == S_IDLE) && idle_pend_r;
  assign start_brk  = en && (state_r == S_IDLE) && !idle_pend_r
                      && ctrl1_r[`UTX_C1_BRK] && !(done_r && (kind_r == K_BRK));
  assign start_data = en && (state_r == S_IDLE) && !idle_pend_r
                      && !ctrl1_r[`UTX_C1_BRK] && !tbe_r;
  assign nbits = ctrl1_r[`UTX_C1_LEN] ? 4'd10 : 4'd9;

  // stop length in ticks
  always @* begin
    case (ctrl2_r[1:0])
      `UTX_STOP_HALF:    stop_sel_len = `UTX_TICKS_HALF;
      `UTX_STOP_TWO:     stop_sel_len = `UTX_TICKS_TWO;
      `UTX_STOP_ONEHALF: stop_sel_len = `UTX_TICKS_ONEH;
      default:           stop_sel_len = `UTX_TICKS_ONE;
    endcase
  end

  // bus capture and register writes; hardware flag updates share this process
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r       <= 1'b0;
      w_got_r        <= 1'b0;
      waddr_r        <= {ADDR_W{1'b0}};
      wdata_r        <= 32'h00000000;
      wstrb_r        <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `UTX_RESP_OKAY;
      ctrl1_r        <= `UTX_RST_CTRL;
      ctrl2_r        <= 4'h0;
      ctrl3_r        <= 3'h0;
      baud_divisor_r <= `UTX_RST_BAUD;
      buf_r          <= 9'h000;
      tbe_r          <= 1'b1;
      tc_r           <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        waddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      // hardware side of the flags
      if (start_data) tbe_r <= 1'b1;
      if (done_r && tbe_r) tc_r <= 1'b1;
      if (done_r && kind_r == K_BRK) ctrl1_r[`UTX_C1_BRK] <= 1'b0;
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `UTX_RESP_OKAY;
        case (waddr_r)
          `UTX_OFS_STATUS: begin
            // write zero clears, but a completion in this cycle wins
            if (wstrb_r[0] && !wdata_r[`UTX_ST_TC] && !(done_r && tbe_r)) tc_r <= 1'b0;
          end
          `UTX_OFS_DATA: begin
            if (wstrb_r[0]) begin
              buf_r <= wval[8:0];
              // a word written as the old one loads must stay pending
              tbe_r <= 1'b0;
            end
          end
          `UTX_OFS_BAUD:  baud_divisor_r <= wval[15:0];
          `UTX_OFS_CTRL1: ctrl1_r <= wval[7:0];
          `UTX_OFS_CTRL2: ctrl2_r <= wval[3:0];
          `UTX_OFS_CTRL3: ctrl3_r <= wval[2:0];
          default: s_axi_bresp <= `UTX_RESP_SLVERR;
        endcase
      end
    end
  end

  // read decode
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `UTX_OFS_STATUS: rd_word = {29'h00000000, (state_r != S_IDLE), tc_r, tbe_r};
      `UTX_OFS_DATA:   rd_word = 32'h00000000;
      `UTX_OFS_BAUD:   rd_word = {16'h0000, baud_divisor_r};
      `UTX_OFS_CTRL1:  rd_word = {24'h000000, ctrl1_r};
      `UTX_OFS_CTRL2:  rd_word = {28'h0000000, ctrl2_r};
      `UTX_OFS_CTRL3:  rd_word = {29'h00000000, ctrl3_r};
      default: begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // read channel: one read in flight, answered the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `UTX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `UTX_RESP_OKAY : `UTX_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // frame sequencer: start and data bits, then stop time counted in ticks
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= S_IDLE;
      kind_r      <= K_DATA;
      shreg_r     <= 10'h3FF;
      tick_cnt_r  <= 4'h0;
      bit_cnt_r   <= 4'h0;
      stop_cnt_r  <= 6'h00;
      stop_len_r  <= `UTX_TICKS_ONE;
      tx_line_r   <= 1'b1;
      en_d_r      <= 1'b0;
      idle_pend_r <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      en_d_r <= en;
      done_r <= 1'b0;
      if (en && !en_d_r) idle_pend_r <= 1'b1;
      if (!en) begin
        // dropping the enable mid frame cuts the frame short
        state_r   <= S_IDLE;
        tx_line_r <= 1'b1;
      end else begin
        case (state_r)
          S_IDLE: begin
            tx_line_r  <= 1'b1;
            tick_cnt_r <= 4'h0;
            bit_cnt_r  <= 4'h0;
            stop_len_r <= stop_sel_len;
            if (start_idle) begin
              idle_pend_r <= 1'b0;
              kind_r      <= K_IDLE;
              shreg_r     <= 10'h3FF;
              state_r     <= S_BITS;
            end else if (start_brk) begin
              kind_r     <= K_BRK;
              shreg_r    <= 10'h000;
              tx_line_r  <= 1'b0;
              state_r    <= S_BITS;
              stop_len_r <= (ctrl2_r[1:0] == `UTX_STOP_TWO) ? `UTX_TICKS_TWO
                                                            : `UTX_TICKS_ONE;
            end else if (start_data) begin
              kind_r    <= K_DATA;
              shreg_r   <= utx_frame(buf_r, ctrl1_r[`UTX_C1_LEN],
                                     ctrl1_r[`UTX_C1_PEN], ctrl1_r[`UTX_C1_PSEL]);
              tx_line_r <= 1'b0;
              state_r   <= S_BITS;
            end
          end
          S_BITS: begin
            if (tick) begin
              tick_cnt_r <= tick_cnt_r + 4'h1;
              if (tick_cnt_r == 4'hF) begin
                shreg_r   <= {1'b1, shreg_r[9:1]};
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (bit_cnt_r == nbits - 4'h1) begin
                  state_r    <= S_STOP;
                  stop_cnt_r <= 6'h00;
                  tx_line_r  <= 1'b1;
                end else begin
                  tx_line_r <= shreg_r[1];
                end
              end
            end
          end
          S_STOP: begin
            if (tick) begin
              stop_cnt_r <= stop_cnt_r + 6'h01;
              if (stop_cnt_r == stop_len_r - 6'h01) begin
                state_r <= S_IDLE;
                done_r  <= 1'b1;
              end
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // clock pin: high in the second half of each data bit, idle low
  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_out_pin <= 1'b0;
    end else begin
      serial_clock_out_pin <= en && ctrl2_r[`UTX_C2_SCE] && (state_r == S_BITS)
                              && (kind_r == K_DATA) && (bit_cnt_r != 4'h0)
                              && tick_cnt_r[3];
    end
  end

  // half-duplex turns the line open-drain and loops it into the receiver
  assign tx_out         = ctrl3_r[`UTX_C3_HD] ? 1'b0 : tx_line_r;
  assign tx_oe          = ctrl3_r[`UTX_C3_HD] ? !tx_line_r : 1'b1;
  assign rx_to_receiver = ctrl3_r[`UTX_C3_HD] ? tx_line_r : rx_in;

  // request level follows the flags, so clearing a flag drops it
  assign irq = (tbe_r & ctrl1_r[`UTX_C1_TBEIE]) | (tc_r & ctrl1_r[`UTX_C1_TCIE]);

endmodule // utx_top

// File: tb/utx_top_chk.sv
// port-level assertion checker for the serial transmitter
`timescale 1ns/1ps
module utx_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic rx_to_receiver,
  input wire logic serial_clock_out_pin,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // clock pin high for the second half of a bit at the reset divisor
  sequence sclk_half_s;
    serial_clock_out_pin [*8] ##1 !serial_clock_out_pin;
  endsequence

  rst_state_a: assert property ($rose(aresetn) |-> tx_out && tx_oe && !irq && !serial_clock_out_pin)
    else $error("outputs not at rest after reset");
  wr_resp_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  hd_drain_a: assert property (!tx_oe |-> !tx_out && rx_to_receiver)
    else $error("released line not looped back high");
  bit_width_a: assert property ($fell(tx_out) |-> !tx_out [*8])
    else $error("low bit shorter than half a bit");
  sclk_pulse_a: assert property ($rose(serial_clock_out_pin) |-> sclk_half_s)
    else $error("clock pin pulse width wrong");
endmodule // utx_top_chk

bind utx_top utx_top_chk u_chk (.*);

// File: tb/utx_peer.sv
// far-end serial model: frame sampler and restless receive pin
`timescale 1ns/1ps
module utx_peer (
  input  wire logic        aclk,
  input  wire logic        line,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] bitc,
  output logic             rx_in,
  output logic [15:0]      word,
  output logic             got
);
  // receive pin toggles every cycle so any leak into the looped path shows up
  initial rx_in = 1'b1;
  always @(posedge aclk) rx_in <= ~rx_in;

  // sample a quarter bit in, so a half stop bit is caught before the next start
  initial begin
    got = 1'b0;
    word = 16'h0000;
    forever begin
      @(negedge line);
      repeat (bitc / 4) @(posedge aclk);
      word = 16'h0000;
      for (int i = 0; i < nbits; i++) begin
        word[i] = line;
        if (i < nbits - 1) repeat (bitc) @(posedge aclk);
      end
      got = 1'b1;
      @(posedge aclk);
      got = 1'b0;
    end
  end
endmodule // utx_peer

// File: tb/utx_top_tb.sv
// self-checking bench for the serial transmitter
`timescale 1ns/1ps
module utx_top_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        tx_out, tx_oe, rx_in, rx_to_receiver, serial_clock_out_pin, irq;
  logic [4:0]  nbits = 5'd10;
  logic [15:0] bitc = 16'h0010;
  logic [15:0] pword;
  logic        pgot;
  logic [1:0]  rmode = 2'h0;
  logic [15:0] expq[$];
  int          err_total = 0, n_tests = 0, cyc = 0, seed = 44, nsclk = 0;
  time         t_prev = 0, t_got = 0, t_en = 0;
  // pull-up on the shared line; the far end never drives it
  wire         line = tx_oe ? tx_out : 1'b1;

  utx_top DUT (.*);
  utx_peer u_peer (.aclk(aclk), .line(line), .nbits(nbits), .bitc(bitc), .rx_in(rx_in),
                   .word(pword), .got(pgot));

  always #4 aclk = ~aclk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // a hang ends the run well past the few thousand cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask

  // bus tasks wait for the answer however long it takes; only the cycle ceiling ends a hang
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    cmp(s_axi_rdata & msk, e, "read data");
  endtask

  // note the expected line image (start, data, parity, stop) then write the word
  task automatic send(input logic [8:0] d, input int nd, input logic pen, input logic odd);
    logic [15:0] w;
    int k;
    w = 16'h0000;
    for (k = 0; k < nd; k++) w[k + 1] = d[k];
    k = nd + 1;
    if (pen) begin
      w[k] = odd;
      for (int j = 0; j < nd; j++) w[k] = w[k] ^ d[j];
      k++;
    end
    w[k] = 1'b1;
    nbits = 5'(k + 1);
    expq.push_back(w);
    axw(8'h04, {23'h0, d}, 2'h0);
  endtask

  task automatic drain(input string m);
    int t;
    t = 0;
    while (expq.size() != 0 && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    if (t >= 3000) cmp(32'h0, 32'h1, "frame never seen");
    repeat (40) @(posedge aclk);
    $display("%0t end of %s", $time, m);
  endtask

  // each sampled frame retires the oldest expectation
  always @(posedge pgot) begin
    t_prev = t_got;
    t_got = $time;
    if (expq.size() == 0) cmp({16'h0, pword}, 32'hFFFFFFFF, "unexpected frame");
    else cmp({16'h0, pword}, {16'h0, expq.pop_front()}, "frame");
  end

  always @(posedge serial_clock_out_pin) nsclk++;

  // receive path: pin in normal mode, own line in single-wire mode; skipped while switching
  always @(negedge aclk)
    if (aresetn && rmode != 2'h2) cmp(32'(rx_to_receiver), 32'(rmode[0] ? line : rx_in), "rx path");

  initial begin
    logic [31:0] v;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, 32'h7, 32'h3, 2'h0);
    axr(8'h08, 32'hFFFF, 32'h10, 2'h0);
    axr(8'h0C, 32'hFF, 32'h0, 2'h0);
    axr(8'h40, 32'hFFFFFFFF, 32'h0, 2'h2);
    axw(8'h40, 32'h1, 2'h2);
    axw(8'h0C, 32'h3, 2'h0);
    t_en = $time;
    send(9'($random(seed)), 8, 1'b0, 1'b0);
    @(negedge line);
    cmp(32'(($time - t_en) >= 150 * 8), 32'h1, "idle frame first");
    drain("idle frame");
    // every length, parity enable and parity sense
    for (int c = 0; c < 8; c++) begin
      axw(8'h0C, 32'(3 + 4 * c), 2'h0);
      send(9'($random(seed)), 8 + c[0] - c[1], c[1], c[2]);
      drain("format");
    end
    axw(8'h0C, 32'h43, 2'h0);
    cmp(32'(irq), 32'h1, "irq on empty buffer");
    send(9'($random(seed)), 8, 1'b0, 1'b0);
    axr(8'h00, 32'h5, 32'h5, 2'h0);
    send(9'($random(seed)), 8, 1'b0, 1'b0);
    axr(8'h00, 32'h1, 32'h0, 2'h0);
    cmp(32'(irq), 32'h0, "irq with word held");
    axw(8'h00, 32'h0, 2'h0);
    axw(8'h0C, 32'h83, 2'h0);
    cmp(32'(irq), 32'h0, "irq while busy");
    drain("flags");
    axr(8'h00, 32'h3, 32'h3, 2'h0);
    cmp(32'(irq), 32'h1, "irq on completion");
    axw(8'h0C, 32'h3, 2'h0);
    // back-to-back pairs: start spacing grows with the stop length
    for (int s = 0; s < 4; s++) begin
      axw(8'h10, 32'(s), 2'h0);
      send(9'($random(seed)), 8, 1'b0, 1'b0);
      send(9'($random(seed)), 8, 1'b0, 1'b0);
      drain("stop bits");
      v = 144 + ((s == 0) ? 16 : (s == 1) ? 8 : (s == 2) ? 32 : 24);
      cmp(32'((t_got - t_prev) / 8 > v - 3 && (t_got - t_prev) / 8 < v + 3), 32'h1, "spacing");
    end
    axw(8'h10, 32'h0, 2'h0);
    nbits = 5'd10;
    expq.push_back(16'h0200);
    axw(8'h0C, 32'h23, 2'h0);
    drain("break");
    axr(8'h0C, 32'h20, 32'h0, 2'h0);
    axw(8'h10, 32'h4, 2'h0);
    v = 32'(nsclk);
    send(9'($random(seed)), 8, 1'b0, 1'b0);
    drain("clock pin");
    cmp(32'(nsclk) - v, 32'h8, "clock pulses");
    axw(8'h10, 32'h0, 2'h0);
    axw(8'h08, 32'h20, 2'h0);
    bitc = 16'h0020;
    send(9'($random(seed)), 8, 1'b0, 1'b0);
    drain("divisor");
    axw(8'h08, 32'h10, 2'h0);
    bitc = 16'h0010;
    rmode = 2'h2;
    axw(8'h14, 32'h1, 2'h0);
    rmode = 2'h1;
    send(9'($random(seed)), 8, 1'b0, 1'b0);
    drain("single wire");
    wrap_up();
  end
endmodule // utx_top_tb
